// >>> core/dcr_pkg.sv
// constants for the deserializer configuration register bank
// assumes a 20 MHz core clock and an APB master with 32-bit data
`default_nettype none
package dcr_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_SPREAD = 8'h03;
   localparam logic [7:0] IDX_LINK = 8'h04;
   localparam logic [7:0] IDX_CONV = 8'h05;
   localparam logic [7:0] IDX_IRQ_STS = 8'h08;
   localparam logic [7:0] IDX_IRQ_MSK = 8'h09;
   localparam int ADDR_SHIFT = 2;
   // reset values
   localparam logic [7:0] RST_SPREAD = 8'h00;
   localparam logic [7:0] RST_LINK = 8'h07;
   localparam logic [7:0] RST_CONV = 8'h29;
   // field positions
   localparam int F_INTERVAL = 6;
   localparam int F_RSVD = 5;
   localparam int F_LOCK = 7;
   localparam int F_OUT_DIS = 6;
   localparam int F_PATTERN = 5;
   localparam int F_SLEEP = 4;
   localparam int F_IFTYPE = 2;
   localparam int F_REV = 1;
   localparam int F_FWD = 0;
   localparam int F_METHOD = 7;
   localparam int F_DRIVE = 6;
   localparam int F_TRACK = 5;
   localparam int F_EQEN = 4;
   localparam logic [3:0] EQ_MAX = 4'hB;
   // interrupt event bits
   localparam int EV_LOCK_UP = 0;
   localparam int EV_LOCK_DN = 1;
   localparam int EV_RECAL = 2;
   localparam int NUM_EV = 3;
   // recalibration intervals
   localparam int CLK_PERIOD_NS = 50;
   localparam int T_A_MS = 2;
   localparam int T_B_MS = 16;
   localparam int T_C_MS = 256;
   localparam int CYC_A = T_A_MS * 1_000_000 / CLK_PERIOD_NS;
   localparam int CYC_B = T_B_MS * 1_000_000 / CLK_PERIOD_NS;
   localparam int CYC_C = T_C_MS * 1_000_000 / CLK_PERIOD_NS;
   localparam int CNT_W = 23;
   typedef enum logic [1:0] {
      IV_ONCE,
      IV_A,
      IV_B,
      IV_C
   } dcr_interval_t;
endpackage
`default_nettype wire

// >>> core/dcr_regs.sv
// configuration and status registers of the link deserializer, APB slave
// assumes synchronous APB3 master on CLK_I; lock and strap inputs come from pins
//
// Contract
// - spread recalibration once, 2ms, 16ms, 256ms
// - divider zero means autocalibrate, else manual
// - status bit 7 mirrors lock pin
// - interface type: I2C, UART, or disabled
// - bit 1 enables reverse channel sending
// - bit 0 enables forward channel receiving
// - method bit drops register address byte
// - drive bit selects boosted output current
// - tracking bit selects full sync tracking
// - equalizer enable bit, resets disabled
// - boost code twelve steps, resets 1001
//
// Local design decision: the APB slave port.
`default_nettype none
module dcr_regs #(
   parameter int unsigned PER_A_CYC = dcr_pkg::CYC_A,
   parameter int unsigned PER_B_CYC = dcr_pkg::CYC_B,
   parameter int unsigned PER_C_CYC = dcr_pkg::CYC_C
) (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic LINK_STATUS_A_I,
   input wire logic TWO_WIRE_SELECT_I,
   input wire logic LOCAL_CHANNEL_ENABLE_I,
   output logic SPREAD_RECAL_O,
   output logic SAW_DIV_AUTO_O,
   output logic [4:0] SAW_DIV_O,
   output logic OUTPUT_DISABLE_O,
   output logic PATTERN_CHECK_O,
   output logic SLEEP_O,
   output logic LOCAL_IF_I2C_O,
   output logic LOCAL_IF_UART_O,
   output logic REV_SEND_EN_O,
   output logic FWD_RECV_EN_O,
   output logic ADDR_METHOD_O,
   output logic DRIVE_BOOST_O,
   output logic SYNC_TRACK_FULL_O,
   output logic EQ_ENABLE_O,
   output logic [3:0] EQ_BOOST_O,
   output logic IRQ_O
);
   // maps a byte address onto a register index, or flags it unmapped
   function automatic logic [8:0] dcr_decode(input logic [7:0] addr);
      logic [7:0] idx;
      logic ok;
      idx = {2'b00, addr[7:2]};
      ok = (addr[1:0] == 2'b00) &&
           (idx == dcr_pkg::IDX_SPREAD || idx == dcr_pkg::IDX_LINK ||
            idx == dcr_pkg::IDX_CONV || idx == dcr_pkg::IDX_IRQ_STS ||
            idx == dcr_pkg::IDX_IRQ_MSK);
      return {ok, idx};
   endfunction

   logic [7:0] spread_q;
   logic [7:0] link_q;
   logic [7:0] conv_q;
   logic [dcr_pkg::NUM_EV-1:0] sts_q;
   logic [dcr_pkg::NUM_EV-1:0] msk_q;
   logic [dcr_pkg::NUM_EV-1:0] ev;
   logic lock_meta_q;
   logic lock_q;
   logic lock_prev_q;
   logic lcc_meta_q;
   logic lcc_q;
   logic sel_meta_q;
   logic sel_q;
   logic strap_done_q;
   logic lcc_strap_q;
   logic [1:0] fill_q;
   logic recal_q;
   logic [dcr_pkg::CNT_W-1:0] cnt_q;
   logic [8:0] dec;
   logic setup;
   logic wr;
   logic lock_rise;
   logic lock_fall;
   logic [dcr_pkg::CNT_W-1:0] period;
   logic [7:0] rd_val;
   dcr_pkg::dcr_interval_t interval;

   assign dec = dcr_decode(PADDR_I);
   assign setup = PSEL_I && !PENABLE_I;
   assign wr = PSEL_I && PENABLE_I && PWRITE_I && dec[8];
   assign interval = dcr_pkg::dcr_interval_t'(spread_q[dcr_pkg::F_INTERVAL +: 2]);

   // pin inputs pass two flops; only the second stage is read
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         lock_meta_q <= 1'b0;
         lock_q <= 1'b0;
         lock_prev_q <= 1'b0;
         lcc_meta_q <= 1'b0;
         lcc_q <= 1'b0;
         sel_meta_q <= 1'b0;
         sel_q <= 1'b0;
      end
      else
      begin
         lock_meta_q <= LINK_STATUS_A_I;
         lock_q <= lock_meta_q;
         lock_prev_q <= lock_q;
         lcc_meta_q <= LOCAL_CHANNEL_ENABLE_I;
         lcc_q <= lcc_meta_q;
         sel_meta_q <= TWO_WIRE_SELECT_I;
         sel_q <= sel_meta_q;
      end
   end

   assign lock_rise = lock_q && !lock_prev_q;
   assign lock_fall = !lock_q && lock_prev_q;

   // strap taken once the synchroniser has filled after reset release
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         fill_q <= 2'h0;
         strap_done_q <= 1'b0;
         lcc_strap_q <= 1'b0;
      end
      else
      begin
         // both stages reset low; wait two edges so a stale low is never latched
         fill_q <= {fill_q[0], 1'b1};
         if (fill_q[1] && !strap_done_q)
         begin
            strap_done_q <= 1'b1;
            lcc_strap_q <= lcc_q;
         end
      end
   end

   // spread-rate recalibration scheduler
   always_comb
   begin
      unique case (interval)
         dcr_pkg::IV_ONCE: period = '0;
         dcr_pkg::IV_A: period = dcr_pkg::CNT_W'(PER_A_CYC - 1);
         dcr_pkg::IV_B: period = dcr_pkg::CNT_W'(PER_B_CYC - 1);
         dcr_pkg::IV_C: period = dcr_pkg::CNT_W'(PER_C_CYC - 1);
      endcase
   end

   // first recal right after lock, then each period while link_status_a
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         cnt_q <= '0;
         recal_q <= 1'b0;
      end
      else if (lock_rise)
      begin
         cnt_q <= period;
         recal_q <= 1'b1;
      end
      else if (lock_q && interval != dcr_pkg::IV_ONCE && cnt_q == '0)
      begin
         cnt_q <= period;
         recal_q <= 1'b1;
      end
      else
      begin
         cnt_q <= (lock_q && cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
         recal_q <= 1'b0;
      end
   end

   // configuration writes; take effect at the access edge only
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         spread_q <= dcr_pkg::RST_SPREAD;
         link_q <= dcr_pkg::RST_LINK;
         conv_q <= dcr_pkg::RST_CONV;
         msk_q <= '0;
      end
      else if (wr)
      begin
         if (dec[7:0] == dcr_pkg::IDX_SPREAD)
         begin
            spread_q <= PWDATA_I[7:0];
            spread_q[dcr_pkg::F_RSVD] <= 1'b0;
         end
         if (dec[7:0] == dcr_pkg::IDX_LINK)
         begin
            // lock bit is read only and never stored
            link_q <= {1'b0, PWDATA_I[6:0]};
         end
         if (dec[7:0] == dcr_pkg::IDX_CONV)
         begin
            conv_q[7:4] <= PWDATA_I[7:4];
            // illegal boost codes are dropped so the step stays valid
            if (PWDATA_I[3:0] <= dcr_pkg::EQ_MAX)
            begin
               conv_q[3:0] <= PWDATA_I[3:0];
            end
         end
         if (dec[7:0] == dcr_pkg::IDX_IRQ_MSK)
         begin
            msk_q <= PWDATA_I[dcr_pkg::NUM_EV-1:0];
         end
      end
   end

   assign ev[dcr_pkg::EV_LOCK_UP] = lock_rise;
   assign ev[dcr_pkg::EV_LOCK_DN] = lock_fall;
   assign ev[dcr_pkg::EV_RECAL] = recal_q;

   // sticky events, write one to clear; a new event beats the clear
   for (genvar i = 0; i < dcr_pkg::NUM_EV; i++)
   begin : g_sts
      always_ff @(posedge CLK_I)
      begin
         if (RST_I)
         begin
            sts_q[i] <= 1'b0;
         end
         else if (ev[i])
         begin
            sts_q[i] <= 1'b1;
         end
         else if (wr && dec[7:0] == dcr_pkg::IDX_IRQ_STS && PWDATA_I[i])
         begin
            sts_q[i] <= 1'b0;
         end
      end
   end

   // read mux; lock bit is live status
   always_comb
   begin
      rd_val = '0;
      if (dec[7:0] == dcr_pkg::IDX_SPREAD)
      begin
         rd_val = spread_q;
      end
      if (dec[7:0] == dcr_pkg::IDX_LINK)
      begin
         rd_val = link_q;
         rd_val[dcr_pkg::F_LOCK] = lock_q;
      end
      if (dec[7:0] == dcr_pkg::IDX_CONV)
      begin
         rd_val = conv_q;
      end
      if (dec[7:0] == dcr_pkg::IDX_IRQ_STS)
      begin
         rd_val = 8'(sts_q);
      end
      if (dec[7:0] == dcr_pkg::IDX_IRQ_MSK)
      begin
         rd_val = 8'(msk_q);
      end
   end

   // answer registered in the setup cycle so data comes from flops
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         PRDATA_O <= '0;
         PSLVERR_O <= 1'b0;
      end
      else if (setup)
      begin
         PRDATA_O <= (!PWRITE_I && dec[8]) ? {24'h00_0000, rd_val} : '0;
         PSLVERR_O <= !dec[8];
      end
   end

   assign PREADY_O = 1'b1; // zero wait states after the setup cycle

   // configuration outputs
   assign SPREAD_RECAL_O = recal_q;
   assign SAW_DIV_O = spread_q[4:0];
   assign SAW_DIV_AUTO_O = (spread_q[4:0] == 5'h0_0);
   assign OUTPUT_DISABLE_O = link_q[dcr_pkg::F_OUT_DIS];
   assign PATTERN_CHECK_O = link_q[dcr_pkg::F_PATTERN];
   assign SLEEP_O = link_q[dcr_pkg::F_SLEEP];
   // strap low or type 1x shuts the local channel; select pin forces two-wire
   assign LOCAL_IF_I2C_O = lcc_strap_q && !link_q[dcr_pkg::F_IFTYPE + 1] &&
                           (sel_q || !link_q[dcr_pkg::F_IFTYPE]);
   assign LOCAL_IF_UART_O = lcc_strap_q && !sel_q &&
                            link_q[dcr_pkg::F_IFTYPE +: 2] == 2'b01;
   assign REV_SEND_EN_O = link_q[dcr_pkg::F_REV];
   assign FWD_RECV_EN_O = link_q[dcr_pkg::F_FWD];
   assign ADDR_METHOD_O = conv_q[dcr_pkg::F_METHOD];
   assign DRIVE_BOOST_O = conv_q[dcr_pkg::F_DRIVE];
   assign SYNC_TRACK_FULL_O = conv_q[dcr_pkg::F_TRACK];
   assign EQ_ENABLE_O = conv_q[dcr_pkg::F_EQEN];
   assign EQ_BOOST_O = conv_q[3:0];
   assign IRQ_O = |(sts_q & msk_q);

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);

   lock_mirror_a: assert property (
      setup && !PWRITE_I && dec[8] && dec[7:0] == dcr_pkg::IDX_LINK
      |=> PRDATA_O[dcr_pkg::F_LOCK] == $past(lock_q))
      else $error("lock bit does not mirror lock input");
   div_auto_a: assert property (
      wr && dec[7:0] == dcr_pkg::IDX_SPREAD
      |=> SAW_DIV_AUTO_O == ($past(PWDATA_I[4:0]) == 5'h00))
      else $error("divider auto flag wrong");
   recal_first_a: assert property (
      lock_rise |=> SPREAD_RECAL_O ##1 !SPREAD_RECAL_O)
      else $error("no single recal pulse after lock");
   recal_once_a: assert property (
      interval == dcr_pkg::IV_ONCE && !lock_rise |=> !SPREAD_RECAL_O)
      else $error("recal repeated in once-only mode");
   if_off_a: assert property (
      link_q[dcr_pkg::F_IFTYPE + 1] || !lcc_strap_q
      |-> !LOCAL_IF_I2C_O && !LOCAL_IF_UART_O)
      else $error("local channel active while disabled");
   rev_write_a: assert property (
      wr && dec[7:0] == dcr_pkg::IDX_LINK |=> REV_SEND_EN_O == $past(PWDATA_I[1]))
      else $error("reverse enable not written");
   fwd_write_a: assert property (
      wr && dec[7:0] == dcr_pkg::IDX_LINK |=> FWD_RECV_EN_O == $past(PWDATA_I[0]))
      else $error("forward enable not written");
   conv_write_a: assert property (
      wr && dec[7:0] == dcr_pkg::IDX_CONV
      |=> {ADDR_METHOD_O, DRIVE_BOOST_O, SYNC_TRACK_FULL_O, EQ_ENABLE_O}
          == $past(PWDATA_I[7:4]))
      else $error("conversion register not written");
   eq_legal_a: assert property (
      EQ_BOOST_O <= dcr_pkg::EQ_MAX)
      else $error("illegal boost code held");
   rsvd_zero_a: assert property (
      setup && dec[7:0] == dcr_pkg::IDX_SPREAD |=> PRDATA_O[dcr_pkg::F_RSVD] == 1'b0)
      else $error("reserved bit read nonzero");
   irq_level_a: assert property (
      lock_rise && msk_q[dcr_pkg::EV_LOCK_UP] && !wr |=> IRQ_O)
      else $error("interrupt not raised");

   lock_cycle_c: cover property (lock_rise ##[1:20] lock_fall);
   periodic_c: cover property (SPREAD_RECAL_O && !$past(lock_rise));
   bad_addr_c: cover property (PSEL_I && PENABLE_I && PSLVERR_O);
endmodule
`default_nettype wire

// >>> test/dcr_serializer_model.sv
// far-side serializer model: raises the lock pin once the link has trained
// assumes link_up_i comes from the bench, driven just after the rising edge
`default_nettype none
module dcr_serializer_model #(
   parameter int TRAIN_CYC = 3
) (
   input wire logic clk_i,
   input wire logic link_up_i,
   output var logic lock_o = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   // lock drops at once when the cable goes away, a slow link trains longer
   always @(posedge clk_i)
   begin
      cnt <= link_up_i ? cnt + 1 : 0;
      lock_o <= link_up_i && cnt >= TRAIN_CYC;
   end
endmodule
`default_nettype wire

// >>> test/deserializer_config_registers_bench.sv
// self-checking bench for the configuration register bank, APB master side
// assumes shortened recalibration periods of 10, 20 and 40 cycles
`default_nettype none
module deserializer_config_registers_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, sel2w = 0, link_up = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, r;
   logic [4:0] div;
   logic [3:0] boost;
   logic pready, pslverr, recal, dauto, odis, pchk, slp, i2c, uart, rev, fwd;
   logic meth, drv, trk, eqen, irq, lock, e;
   logic strap = 1;
   logic [7:0] v, m4, m5;
   logic [15:0] rnd = 16'h4E98;
   int miscompares = 0, n_tests = 0, n;
   int per[4] = '{0, 10, 20, 40};
   dcr_serializer_model #(.TRAIN_CYC(3)) far (.clk_i(clk), .link_up_i(link_up), .lock_o(lock));
   // strap starts high; a second power-up takes it low
   dcr_regs #(.PER_A_CYC(10), .PER_B_CYC(20), .PER_C_CYC(40)) dut (
      .CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .LINK_STATUS_A_I(lock), .TWO_WIRE_SELECT_I(sel2w),
      .LOCAL_CHANNEL_ENABLE_I(strap), .SPREAD_RECAL_O(recal), .SAW_DIV_AUTO_O(dauto),
      .SAW_DIV_O(div), .OUTPUT_DISABLE_O(odis), .PATTERN_CHECK_O(pchk), .SLEEP_O(slp),
      .LOCAL_IF_I2C_O(i2c), .LOCAL_IF_UART_O(uart), .REV_SEND_EN_O(rev),
      .FWD_RECV_EN_O(fwd), .ADDR_METHOD_O(meth), .DRIVE_BOOST_O(drv),
      .SYNC_TRACK_FULL_O(trk), .EQ_ENABLE_O(eqen), .EQ_BOOST_O(boost), .IRQ_O(irq));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic end_of_test;
      if (miscompares == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic fail_out;
      miscompares++;
      end_of_test();
   endtask
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one APB transfer; the request stands until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1;
      pen <= 0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      if (k == 20)
         fail_out();
      r = prdata;
      e = pslverr;
      psel <= 0;
      pen <= 0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] x);
      rnd = lfsr(rnd);
      apb(1, idx << 2, {rnd, rnd[7:0], x});
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] x);
      apb(0, idx << 2, '0);
      chk({7'h00, e, r}, {32'h0000_0000, x});
   endtask
   // cycles from now to the next recalibration pulse, -1 if none
   task automatic gap(input int lim, output int g);
      g = -1;
      for (int k = 1; k <= lim && g < 0; k++)
      begin
         @(negedge clk);
         if (recal === 1'b1)
            g = k;
      end
   endtask
   task automatic irq_is(input logic x);
      repeat (2) @(negedge clk);
      chk({39'h0, irq}, {39'h0, x});
      @(posedge clk);
   endtask
   initial
      forever #25 clk = ~clk;
   initial
   begin
      #5000000;
      fail_out();
   end
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 0;
      repeat (4) @(posedge clk);
      rd(3, 8'h00);
      rd(4, 8'h07);
      rd(5, 8'h29);
      // divider: zero means self-calibration, the reserved bit never sticks
      for (int i = 0; i < 4; i++)
      begin
         rnd = lfsr(rnd);
         v = i == 0 ? 8'hC0 : (i == 3 ? 8'hFF : rnd[7:0]);
         wr(3, v);
         rd(3, v & 8'hDF);
         chk({34'h0, dauto, div}, {34'h0, v[4:0] == 5'h00, v[4:0]});
      end
      // interface type against the select pin, random other bits
      for (int t = 0; t < 4; t++)
         for (int s = 0; s < 2; s++)
         begin
            rnd = lfsr(rnd);
            sel2w <= s[0];
            m4 = {1'b1, rnd[6:4], t[1:0], rnd[1:0]};
            wr(4, m4);
            repeat (4) @(posedge clk);
            rd(4, {1'b0, m4[6:0]});
            chk({38'h0, i2c, uart}, {38'h0, t == 0 || (t == 1 && s == 1), t == 1 && s == 0});
            chk({35'h0, odis, pchk, slp, rev, fwd}, {35'h0, m4[6:4], m4[1:0]});
         end
      // every boost code; the forbidden ones leave the old code in place
      m5 = 8'h29;
      for (int k = 0; k < 16; k++)
      begin
         rnd = lfsr(rnd);
         v = {rnd[3:0], k[3:0]};
         m5 = k < 12 ? v : {v[7:4], m5[3:0]};
         wr(5, v);
         rd(5, m5);
         chk({32'h0, meth, drv, trk, eqen, boost}, {32'h0, m5});
      end
      // unmapped and misaligned places are refused
      apb(0, 8'h18, '0);
      chk({7'h00, e, r}, {8'h01, 32'h0000_0000});
      apb(1, 8'h0D, 32'h0000_00FF);
      chk({39'h0, e}, 40'h00_0000_0001);
      rd(3, 8'hDF);
      for (int c = 0; c < 4; c++)
      begin
         wr(3, {c[1:0], 6'h00});
         link_up <= 1;
         gap(100, n);
         if (n < 0)
            fail_out();
         gap(150, n);
         chk(40'(n), 40'(c == 0 ? -1 : per[c]));
         rd(4, {1'b1, m4[6:0]});
         if (c == 0)
         begin
            rd(8, 8'h05);
            irq_is(0);
            wr(9, 8'h01);
            irq_is(1);
            wr(8, 8'h01);
            irq_is(0);
         end
         link_up <= 0;
         repeat (6) @(posedge clk);
         if (c == 0)
         begin
            rd(8, 8'h06);
            wr(9, 8'h02);
            irq_is(1);
            wr(8, 8'h07);
            rd(8, 8'h00);
            irq_is(0);
         end
      end
      // second power-up with the strap low: local channel stays off
      sel2w <= 0;
      strap <= 0;
      rst <= 1;
      repeat (8) @(posedge clk);
      rst <= 0;
      repeat (4) @(posedge clk);
      rd(4, 8'h07);
      rd(5, 8'h29);
      rd(8, 8'h00);
      chk({38'h0, i2c, uart}, 40'h00_0000_0000);
      // the strap is latched at power-up, so raising it later changes nothing
      strap <= 1;
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk({38'h0, i2c, uart}, 40'h00_0000_0000);
      end_of_test();
   end
endmodule
`default_nettype wire
